// File: verilog/eiu_top.sv
// Purpose: interrupt selection, polling, enable/priority registers and serial error flags
// Assumes: all event inputs come from logic on ref_clk; cpu acks a request with vec_ack
// Notes: a machine cycle is twelve clock edges; results appear one machine cycle late
`include "eiu_map.svh"
`timescale 1ns/1ps
`default_nettype none
module eiu_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic sfr_bit_wr,
  input wire logic [7:0] sfr_bit_addr,
  input wire logic sfr_bit_val,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic vec_ack,
  input wire logic reti,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic irq_level,
  output logic [3:0] irq_source,
  input wire logic ext0_flag,
  input wire logic ext1_flag,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic uart_txrx_irq,
  input wire logic rx_fifo_not_empty,
  input wire logic tx_fifo_not_full,
  input wire logic dma_service,
  input wire logic collision_mode,
  input wire logic hw_ack_enable,
  input wire logic tx_enable_set,
  input wire logic rx_enable_set,
  input wire logic tx_frame_end,
  input wire logic rx_frame_end,
  input wire logic coll_detect,
  input wire logic transmit_fifo_accessed,
  input wire logic collision_counter_ovf,
  input wire logic transmit_fifo_fetch_empty,
  input wire logic tx_dma_chan,
  input wire logic ifs_ack_timeout,
  input wire logic ifs_collision,
  input wire logic ifs_last_bit_active,
  input wire logic rx_crc_err,
  input wire logic rx_align_err,
  input wire logic rx_abort,
  input wire logic rx_overrun,
  input wire logic tx_data_bit,
  input wire logic [15:0] chan0_byte_count,
  input wire logic [15:0] chan1_byte_count,
  input wire logic [1:0] chan_done_sw_set,
  input wire logic [1:0] chan_done_sw_clr,
  output logic [1:0] chan_done,
  output logic tx_collision_flag,
  output logic tx_underrun_flag,
  output logic no_ack_flag,
  output logic [3:0] rx_error_flags,
  output logic transmit_enable_bit,
  output logic receive_enable_bit,
  output logic tx_done_flag,
  output logic rx_done_flag,
  output logic tx_start_check,
  output logic tx_check_en,
  output logic tx_close_flag_en,
  output logic serial_tx_pin
);
  logic [7:0] ie_basic;
  logic [7:0] ip_basic;
  logic [7:0] ie_ext;
  logic [7:0] ip_ext;
  logic [3:0] phase;
  logic [10:0] flags;
  logic [10:0] samp;
  logic [10:0] en_vec;
  logic [10:0] hi_vec;
  logic [10:0] ack_mask;
  logic pick_found;
  logic [3:0] pick_idx;
  logic pick_level;
  logic [15:0] next_vector;
  eiu_pkg::eiu_svc_e svc;
  logic set_coll;
  logic set_ur;
  logic set_no_ack_flag;
  logic tx_err_any;
  logic rx_err_any;
  logic [3:0] rx_err_set;
  logic [15:0] svc_count;
  logic [15:0] chan_count [2];

  // byte or bit write into one register; unimplemented bits are masked away
  function automatic logic [7:0] wr_val(input logic [7:0] cur, input logic [7:0] addr, input logic [7:0] mask);
    logic [7:0] v;
    v = cur;
    if (sfr_wr && sfr_addr == addr) begin
      v = sfr_wdata;
    end else if (sfr_bit_wr && sfr_bit_addr[7:3] == addr[7:3]) begin
      v[sfr_bit_addr[2:0]] = sfr_bit_val;
    end
    return v & mask;
  endfunction

  // enable and priority registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ie_basic <= `EIU_RST_REG;
      ip_basic <= `EIU_RST_REG;
      ie_ext <= `EIU_RST_REG;
      ip_ext <= `EIU_RST_REG;
    end else begin
      ie_basic <= wr_val(ie_basic, `EIU_ADDR_IE, `EIU_MASK_IE);
      ip_basic <= wr_val(ip_basic, `EIU_ADDR_IP, `EIU_MASK_IP);
      ie_ext <= wr_val(ie_ext, `EIU_ADDR_INTERRUPT_ENABLE_EXTENDED, `EIU_MASK_INTERRUPT_ENABLE_EXTENDED);
      ip_ext <= wr_val(ip_ext, `EIU_ADDR_INTERRUPT_PRIORITY_EXTENDED, `EIU_MASK_INTERRUPT_PRIORITY_EXTENDED);
    end
  end

  // read port; unimplemented bits read as zero, which callers must not rely on
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'b0;
    end else if (!sfr_rd) begin
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'b0;
    end else if (sfr_addr == `EIU_ADDR_IE) begin
      sfr_rdata <= ie_basic;
      sfr_hit <= 1'b1;
    end else if (sfr_addr == `EIU_ADDR_IP) begin
      sfr_rdata <= ip_basic;
      sfr_hit <= 1'b1;
    end else if (sfr_addr == `EIU_ADDR_INTERRUPT_ENABLE_EXTENDED) begin
      sfr_rdata <= ie_ext;
      sfr_hit <= 1'b1;
    end else if (sfr_addr == `EIU_ADDR_INTERRUPT_PRIORITY_EXTENDED) begin
      sfr_rdata <= ip_ext;
      sfr_hit <= 1'b1;
    end else begin
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'b0;
    end
  end

  // machine cycle state counter, S1P1 at zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst || phase == `EIU_PHASE_LAST) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // flag, enable and priority vectors in polling order
  always_comb begin
    flags = '0;
    flags[`EIU_SRC_X0] = ext0_flag;
    flags[`EIU_SRC_RXV] = dma_service ? rx_done_flag : rx_fifo_not_empty;
    flags[`EIU_SRC_T0] = timer0_overflow;
    flags[`EIU_SRC_RXE] = rx_err_any;
    flags[`EIU_SRC_CH0] = chan_done[0];
    flags[`EIU_SRC_X1] = ext1_flag;
    flags[`EIU_SRC_TXV] = dma_service ? tx_done_flag : tx_fifo_not_full;
    flags[`EIU_SRC_CH1] = chan_done[1];
    flags[`EIU_SRC_T1] = timer1_overflow;
    flags[`EIU_SRC_TXE] = tx_err_any;
    flags[`EIU_SRC_UART] = uart_txrx_irq;
    en_vec = {ie_basic[`EIU_BIT_UART], ie_ext[`EIU_BIT_TXE], ie_basic[`EIU_BIT_T1], ie_ext[`EIU_BIT_CH1],
              ie_ext[`EIU_BIT_TXV], ie_basic[`EIU_BIT_X1], ie_ext[`EIU_BIT_CH0], ie_ext[`EIU_BIT_RXE],
              ie_basic[`EIU_BIT_T0], ie_ext[`EIU_BIT_RXV], ie_basic[`EIU_BIT_X0]};
    hi_vec = {ip_basic[`EIU_BIT_UART], ip_ext[`EIU_BIT_TXE], ip_basic[`EIU_BIT_T1], ip_ext[`EIU_BIT_CH1],
              ip_ext[`EIU_BIT_TXV], ip_basic[`EIU_BIT_X1], ip_ext[`EIU_BIT_CH0], ip_ext[`EIU_BIT_RXE],
              ip_basic[`EIU_BIT_T0], ip_ext[`EIU_BIT_RXV], ip_basic[`EIU_BIT_X0]};
    ack_mask = (vec_ack && irq_req) ? (11'h001 << irq_source) : 11'h000;
  end

  // sample at S5P2; a just-vectored source is dropped so it cannot be taken twice
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      samp <= '0;
    end else if (phase == `EIU_PHASE_SAMPLE) begin
      samp <= flags & ~ack_mask;
    end else begin
      samp <= samp & ~ack_mask;
    end
  end

  eiu_poll_pick #(
    .N(`EIU_NUM_SRC),
    .IW(4)
  ) u_pick (
    .req(samp & en_vec & {11{ie_basic[`EIU_BIT_EA]}}),
    .hi(hi_vec),
    .allow_hi(svc == eiu_pkg::SVC_NONE || svc == eiu_pkg::SVC_LOW),
    .allow_lo(svc == eiu_pkg::SVC_NONE),
    .found(pick_found),
    .idx(pick_idx),
    .level(pick_level)
  );

  // fixed vector per poll position
  always_comb begin
    case (pick_idx)
      `EIU_SRC_X0: next_vector = `EIU_VEC_X0;
      `EIU_SRC_RXV: next_vector = `EIU_VEC_RXV;
      `EIU_SRC_T0: next_vector = `EIU_VEC_T0;
      `EIU_SRC_RXE: next_vector = `EIU_VEC_RXE;
      `EIU_SRC_CH0: next_vector = `EIU_VEC_CH0;
      `EIU_SRC_X1: next_vector = `EIU_VEC_X1;
      `EIU_SRC_TXV: next_vector = `EIU_VEC_TXV;
      `EIU_SRC_CH1: next_vector = `EIU_VEC_CH1;
      `EIU_SRC_T1: next_vector = `EIU_VEC_T1;
      `EIU_SRC_TXE: next_vector = `EIU_VEC_TXE;
      default: next_vector = `EIU_VEC_UART;
    endcase
  end

  // poll result registered once per machine cycle, just before the next sample
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_req <= 1'b0;
      irq_vector <= 16'h0000;
      irq_level <= 1'b0;
      irq_source <= 4'h0;
    end else if (phase == `EIU_PHASE_POLL) begin
      irq_req <= pick_found;
      irq_vector <= next_vector;
      irq_level <= pick_level;
      irq_source <= pick_idx;
    end else if (vec_ack) begin
      irq_req <= 1'b0;
    end
  end

  // in-service level state; high may nest over low, never the reverse
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      svc <= eiu_pkg::SVC_NONE;
    end else if (vec_ack && irq_req) begin
      case (svc)
        eiu_pkg::SVC_NONE: svc <= irq_level ? eiu_pkg::SVC_HIGH : eiu_pkg::SVC_LOW;
        eiu_pkg::SVC_LOW: svc <= eiu_pkg::SVC_BOTH;
        default: svc <= svc;
      endcase
    end else if (reti) begin
      case (svc)
        eiu_pkg::SVC_BOTH: svc <= eiu_pkg::SVC_LOW;
        default: svc <= eiu_pkg::SVC_NONE;
      endcase
    end
  end

  // per-channel done flags: set wins over any clear in the same cycle
  assign chan_count[0] = chan0_byte_count;
  assign chan_count[1] = chan1_byte_count;
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [15:0] prev_count;
    logic hit_zero;
    logic vec_clr;
    assign hit_zero = (chan_count[c] == 16'h0000) && (prev_count != 16'h0000);
    assign vec_clr = ack_mask[c == 0 ? `EIU_SRC_CH0 : `EIU_SRC_CH1];
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        prev_count <= 16'h0000;
        chan_done[c] <= 1'b0;
      end else begin
        prev_count <= chan_count[c];
        chan_done[c] <= (chan_done[c] & ~(vec_clr | chan_done_sw_clr[c])) | hit_zero | chan_done_sw_set[c];
      end
    end
  end

  // transmit error events, gated by mode
  assign svc_count = tx_dma_chan ? chan1_byte_count : chan0_byte_count;
  assign set_coll = collision_mode && ((coll_detect && transmit_enable_bit && transmit_fifo_accessed) || collision_counter_ovf);
  assign set_ur = dma_service && transmit_fifo_fetch_empty && (svc_count != 16'h0000);
  assign set_no_ack_flag = collision_mode && hw_ack_enable && (ifs_ack_timeout || ifs_collision || ifs_last_bit_active);
  assign tx_err_any = tx_collision_flag || tx_underrun_flag || no_ack_flag;

  // read-only error flags, cleared only by software setting transmit enable
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_collision_flag <= 1'b0;
      tx_underrun_flag <= 1'b0;
      no_ack_flag <= 1'b0;
    end else begin
      tx_collision_flag <= (tx_collision_flag && !tx_enable_set) || set_coll;
      tx_underrun_flag <= (tx_underrun_flag && !tx_enable_set) || set_ur;
      no_ack_flag <= (no_ack_flag && !tx_enable_set) || set_no_ack_flag;
    end
  end

  // transmit enable: software set, any error clears it and aborts the frame
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      transmit_enable_bit <= 1'b0;
      tx_done_flag <= 1'b0;
    end else begin
      if (tx_enable_set) begin
        transmit_enable_bit <= 1'b1;
      end else if (tx_err_any) begin
        transmit_enable_bit <= 1'b0;
      end
      tx_done_flag <= (tx_done_flag && !tx_enable_set) || (tx_frame_end && !tx_err_any);
    end
  end

  // frame end handling and line drive on abort in collision mode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_start_check <= 1'b0;
      tx_check_en <= 1'b0;
      tx_close_flag_en <= 1'b0;
      serial_tx_pin <= 1'b1;
    end else begin
      tx_start_check <= !dma_service && transmit_fifo_fetch_empty && transmit_enable_bit && !tx_err_any;
      tx_check_en <= transmit_enable_bit && !tx_err_any;
      tx_close_flag_en <= !tx_err_any;
      serial_tx_pin <= (collision_mode && tx_err_any) ? 1'b1 : tx_data_bit;
    end
  end

  // receive errors mirror the transmit side; an error blocks receive done
  assign rx_err_set = {rx_overrun, rx_abort, rx_align_err, rx_crc_err};
  assign rx_err_any = |rx_error_flags;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_error_flags <= 4'h0;
      receive_enable_bit <= 1'b0;
      rx_done_flag <= 1'b0;
    end else begin
      rx_error_flags <= (rx_error_flags & ~{4{rx_enable_set}}) | rx_err_set;
      if (rx_enable_set) begin
        receive_enable_bit <= 1'b1;
      end else if (rx_err_any) begin
        receive_enable_bit <= 1'b0;
      end
      rx_done_flag <= (rx_done_flag && !rx_enable_set) || (rx_frame_end && !rx_err_any && !(|rx_err_set));
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_rx_src_fifo: assert property ((phase == `EIU_PHASE_SAMPLE && !dma_service && !vec_ack)
    |=> samp[`EIU_SRC_RXV] == $past(rx_fifo_not_empty)) else $error("rx valid not from fifo flag");
  a_rx_src_done: assert property ((phase == `EIU_PHASE_SAMPLE && dma_service && !vec_ack)
    |=> samp[`EIU_SRC_RXV] == $past(rx_done_flag)) else $error("rx valid not from done flag");
  a_tx_src_sel: assert property ((phase == `EIU_PHASE_SAMPLE && !vec_ack)
    |=> samp[`EIU_SRC_TXV] == $past(dma_service ? tx_done_flag : tx_fifo_not_full)) else $error("tx valid source");
  a_sample_moment: assert property (!$stable(samp) |-> ($past(phase) == `EIU_PHASE_SAMPLE || $past(vec_ack)))
    else $error("samples changed off S5P2");
  a_poll_moment: assert property ($rose(irq_req) |-> $past(phase) == `EIU_PHASE_POLL)
    else $error("request raised off poll time");
  a_level_gate: assert property (irq_req |-> (irq_level ? (svc != eiu_pkg::SVC_HIGH && svc != eiu_pkg::SVC_BOTH)
    : svc == eiu_pkg::SVC_NONE)) else $error("request at blocked level");
  a_unimpl_read: assert property ((sfr_rd && sfr_addr == `EIU_ADDR_IE) |=> sfr_rdata[6:5] == 2'b00)
    else $error("unimplemented bits stored");
  a_chan_vec_clr: assert property ((vec_ack && irq_req && irq_source == `EIU_SRC_CH0 && !chan_done_sw_set[0]
    && chan0_byte_count == 16'h0000) |=> !chan_done[0]) else $error("done flag kept after vectoring");
  a_tx_flag_clr: assert property ($fell(tx_err_any) |-> $past(tx_enable_set))
    else $error("tx error flag cleared without enable set");
  a_ten_abort: assert property ((tx_err_any && !tx_enable_set) |=> !transmit_enable_bit ##1 (!transmit_enable_bit || $past(tx_enable_set)))
    else $error("transmit enable kept after error");
  a_abort_line: assert property ((collision_mode && tx_err_any) |=> (serial_tx_pin && !tx_check_en))
    else $error("line not held high on abort");
  a_coll_gate: assert property ($rose(tx_collision_flag) |-> $past(collision_mode))
    else $error("collision flag outside collision mode");
  a_ur_gate: assert property ($rose(tx_underrun_flag) |-> $past(dma_service && svc_count != 16'h0000))
    else $error("underrun without dma service");
  a_no_ack_flag_gate: assert property ($rose(no_ack_flag) |-> $past(collision_mode && hw_ack_enable))
    else $error("no-ack outside hardware ack mode");
  a_rx_abort: assert property ((rx_err_any && !rx_enable_set) |=> (!receive_enable_bit && !$rose(rx_done_flag)))
    else $error("receive not stopped on error");
endmodule
`default_nettype wire

// File: verilog/eiu_map.svh
// Purpose: addresses, field positions, reset values and timing counts of the extended interrupt unit
// Assumes: included by its bare name; definitions only
// Notes: poll indices double as source numbers; a lower index is polled earlier
`ifndef EIU_MAP_SVH
`define EIU_MAP_SVH

`define EIU_ADDR_IE 8'hA8
`define EIU_ADDR_IP 8'hB8
`define EIU_ADDR_INTERRUPT_ENABLE_EXTENDED 8'hC8
`define EIU_ADDR_INTERRUPT_PRIORITY_EXTENDED 8'hF8

`define EIU_MASK_IE 8'h9F
`define EIU_MASK_IP 8'h1F
`define EIU_MASK_INTERRUPT_ENABLE_EXTENDED 8'h3F
`define EIU_MASK_INTERRUPT_PRIORITY_EXTENDED 8'h3F
`define EIU_RST_REG 8'h00

`define EIU_BIT_EA 7
`define EIU_BIT_UART 4
`define EIU_BIT_T1 3
`define EIU_BIT_X1 2
`define EIU_BIT_T0 1
`define EIU_BIT_X0 0
`define EIU_BIT_TXE 5
`define EIU_BIT_CH1 4
`define EIU_BIT_TXV 3
`define EIU_BIT_CH0 2
`define EIU_BIT_RXE 1
`define EIU_BIT_RXV 0

`define EIU_SRC_X0 4'h0
`define EIU_SRC_RXV 4'h1
`define EIU_SRC_T0 4'h2
`define EIU_SRC_RXE 4'h3
`define EIU_SRC_CH0 4'h4
`define EIU_SRC_X1 4'h5
`define EIU_SRC_TXV 4'h6
`define EIU_SRC_CH1 4'h7
`define EIU_SRC_T1 4'h8
`define EIU_SRC_TXE 4'h9
`define EIU_SRC_UART 4'hA
`define EIU_NUM_SRC 11

`define EIU_VEC_X0 16'h0003
`define EIU_VEC_RXV 16'h002B
`define EIU_VEC_T0 16'h000B
`define EIU_VEC_RXE 16'h0033
`define EIU_VEC_CH0 16'h003B
`define EIU_VEC_X1 16'h0013
`define EIU_VEC_TXV 16'h0043
`define EIU_VEC_CH1 16'h0053
`define EIU_VEC_T1 16'h001B
`define EIU_VEC_TXE 16'h004B
`define EIU_VEC_UART 16'h0023

`define EIU_PHASE_LAST 4'hB
`define EIU_PHASE_SAMPLE 4'h9
`define EIU_PHASE_POLL 4'h8

`endif

// File: verilog/eiu_pkg.sv
// Purpose: shared types of the extended interrupt unit
// Assumes: used as eiu_pkg::name, never imported
// Notes: service state tracks which levels have a handler running
package eiu_pkg;
  typedef enum logic [1:0] {
    SVC_NONE = 2'b00,
    SVC_LOW = 2'b01,
    SVC_HIGH = 2'b10,
    SVC_BOTH = 2'b11
  } eiu_svc_e;
  typedef logic [3:0] eiu_src_t;
endpackage

// File: verilog/eiu_poll_pick.sv
// Purpose: fixed-order two-level pick among pending requests
// Assumes: request bit 0 is polled first
// Notes: purely combinational; caller registers the result
`timescale 1ns/1ps
`default_nettype none
module eiu_poll_pick #(
  parameter int N = 11,
  parameter int IW = 4
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] hi,
  input wire logic allow_hi,
  input wire logic allow_lo,
  output logic found,
  output logic [IW-1:0] idx,
  output logic level
);
  logic found_h;
  logic found_l;
  logic [IW-1:0] idx_h;
  logic [IW-1:0] idx_l;

  // descending scan so the earliest entry overwrites later ones
  always_comb begin
    found_h = 1'b0;
    found_l = 1'b0;
    idx_h = '0;
    idx_l = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && hi[i]) begin
        found_h = 1'b1;
        idx_h = IW'(i);
      end
      if (req[i] && !hi[i]) begin
        found_l = 1'b1;
        idx_l = IW'(i);
      end
    end
  end

  // high level beats low; only two levels exist
  always_comb begin
    found = 1'b0;
    idx = '0;
    level = 1'b0;
    if (found_h && allow_hi) begin
      found = 1'b1;
      idx = idx_h;
      level = 1'b1;
    end else if (found_l && allow_lo) begin
      found = 1'b1;
      idx = idx_l;
    end
  end
endmodule
`default_nettype wire

// File: sim/eiu_cpu_model.sv
// Purpose: cpu core stand-in that vectors to the requested handler
// Assumes: changes its pins on the falling edge, one handler at a time
// Notes: hold sets how long a handler runs, so returns can be prompt or slow
`timescale 1ns/1ps
`default_nettype none
module eiu_cpu_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic irq_level,
  input wire logic [7:0] hold,
  output var logic vec_ack,
  output var logic reti,
  output var logic busy,
  output var logic [16:0] last,
  output var logic [7:0] got
);
  logic [7:0] cnt;
  // quiet pins before the first falling edge
  initial begin
    vec_ack = 1'b0;
    reti = 1'b0;
  end
  // take a request, run the handler for hold cycles, then return once
  always @(negedge ref_clk) begin
    vec_ack <= 1'b0;
    reti <= 1'b0;
    if (sys_rst) begin
      busy <= 1'b0;
      got <= 8'h00;
      cnt <= 8'h00;
      last <= 17'h00000;
    end else if (!busy && irq_req && !vec_ack) begin
      vec_ack <= 1'b1;
      last <= {irq_level, irq_vector};
      got <= got + 8'h01;
      busy <= 1'b1;
      cnt <= hold;
    end else if (busy && cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (busy) begin
      reti <= 1'b1; // one return per vectoring
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: sim/tb_extended_interrupt_unit.sv
// Purpose: self-checking bench for the extended interrupt unit
// Assumes: inputs change on the falling edge; cpu model answers requests
// Notes: handlers clear their source before returning, so no stale repeat
`timescale 1ns/1ps
`default_nettype none
module tb_extended_interrupt_unit;
  logic ref_clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00, hold = 8'h28, sfr_rdata, got;
  logic [10:0] src = 11'h000;
  logic [15:0] ev = 16'h0000, chan0_byte_count = 16'h0001, chan1_byte_count = 16'h0000, irq_vector;
  logic [1:0] chan_done_sw_clr = 2'b00, chan_done;
  logic dma_service = 1'b0, collision_mode = 1'b1, hw_ack_enable = 1'b0, transmit_fifo_accessed = 1'b1;
  logic tx_dma_chan = 1'b0, tx_data_bit = 1'b0, sfr_hit, vec_ack, reti, busy, irq_req, irq_level;
  logic tx_collision_flag, transmit_enable_bit, serial_tx_pin, tx_check_en;
  logic [3:0] rx_error_flags;
  logic [16:0] last;
  int failures = 0, compares = 0;
  localparam logic [7:0] AD[4] = '{8'hA8, 8'hB8, 8'hC8, 8'hF8};
  localparam logic [7:0] MK[4] = '{8'h9F, 8'h1F, 8'h3F, 8'h3F};
  localparam logic [15:0] VEC[11] = '{16'h0003, 16'h002B, 16'h000B, 16'h0033, 16'h003B, 16'h0013,
    16'h0043, 16'h0053, 16'h001B, 16'h004B, 16'h0023};
  localparam logic [10:0] PULSED = 11'h298;
  eiu_top dut_u (.*, .ext0_flag(src[0]), .rx_fifo_not_empty(src[1]), .timer0_overflow(src[2]), .ext1_flag(src[5]),
    .tx_fifo_not_full(src[6]), .timer1_overflow(src[8]), .uart_txrx_irq(src[10]), .tx_enable_set(ev[0]),
    .rx_enable_set(ev[1]), .rx_frame_end(ev[2]), .rx_crc_err(ev[3]), .chan_done_sw_set({ev[7], ev[4]}),
    .tx_frame_end(ev[5]), .coll_detect(ev[6]), .transmit_fifo_fetch_empty(ev[8]), .collision_counter_ovf(ev[9]),
    .ifs_ack_timeout(ev[10]), .ifs_collision(ev[11]), .ifs_last_bit_active(ev[12]), .rx_align_err(ev[13]),
    .rx_abort(ev[14]), .rx_overrun(ev[15]), .tx_underrun_flag(), .no_ack_flag(), .receive_enable_bit(),
    .tx_done_flag(), .rx_done_flag(), .tx_start_check(), .tx_close_flag_en(), .irq_source());
  eiu_cpu_model cpu_u (.*);
  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;
  task automatic end_sim;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic bw(input logic [7:0] a, input logic v);
    @(negedge ref_clk);
    sfr_bit_addr = a;
    sfr_bit_val = v;
    sfr_bit_wr = 1'b1;
    @(negedge ref_clk);
    sfr_bit_wr = 1'b0;
  endtask
  // read data and hit are registered, seen one cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [8:0] e);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    chk({8'h00, sfr_hit, sfr_rdata}, {8'h00, e});
  endtask
  task automatic pulse(input int b);
    @(negedge ref_clk);
    ev[b] = 1'b1;
    @(negedge ref_clk);
    ev[b] = 1'b0;
  endtask
  // no request may reach the cpu within thirty clocks, two and a half machine cycles
  task automatic quiet;
    logic [7:0] g0;
    g0 = got;
    repeat (30) @(negedge ref_clk);
    chk({9'h000, got}, {9'h000, g0});
  endtask
  // wait for a vectoring, clear the source as a handler would, then check
  task automatic serve(input logic [16:0] e);
    logic [7:0] g0;
    g0 = got;
    for (int i = 0; i < 60 && got == g0; i++) @(negedge ref_clk);
    if (got == g0) begin
      failures++;
      end_sim();
    end
    src = 11'h000;
    pulse(0);
    pulse(1);
    chk(last, e);
    chk({10'h000, chan_done, rx_error_flags, tx_collision_flag}, 17'h00000);
    for (int i = 0; i < 80 && busy; i++) @(negedge ref_clk);
  endtask
  // main sequence
  initial begin
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rdc(AD[i], {1'b1, 8'h00});
      wr(AD[i], 8'hFF);
      rdc(AD[i], {1'b1, MK[i]});
      wr(AD[i], 8'h00);
    end
    rdc(8'h90, 9'h000);
    wr(8'hA8, 8'h9F);
    wr(8'hC8, 8'h3F);
    for (int i = 0; i < 11; i++) begin
      if (PULSED[i])
        pulse(i);
      else
        src[i] = 1'b1;
      serve({1'b0, VEC[i]});
    end
    bw(8'hAF, 1'b0);
    src = 11'h001;
    quiet();
    bw(8'hAF, 1'b1);
    serve({1'b0, 16'h0003});
    dma_service = 1'b1;
    src = 11'h042;
    quiet();
    pulse(2);
    serve({1'b0, 16'h002B});
    pulse(5);
    serve({1'b0, 16'h0043});
    dma_service = 1'b0;
    pulse(0);
    pulse(6);
    repeat (2) @(negedge ref_clk);
    chk({13'h0000, transmit_enable_bit, serial_tx_pin, tx_check_en, tx_collision_flag}, 17'h00005);
    serve({1'b0, 16'h004B});
    src = 11'h405;
    serve({1'b0, 16'h0003});
    wr(8'hB8, 8'h10);
    wr(8'hF8, 8'h01);
    src = 11'h403;
    serve({1'b1, 16'h002B});
    end_sim();
  end
endmodule
`default_nettype wire
